// ---- logic/pam_pkg.sv ----
// Package of constants and types for the program address mapper.
// =====================================================================
// How it works
// - Reset leaves the mapper in kernel mode.
// - Kernel mode reaches every program address without a privilege trap.
// - User mode traps on any program address with the top bit set.
// - User mode traps any system control coprocessor or privileged instruction.
// - Mode never changes translation; low addresses map alike in both modes.
// - User segment addresses gain a one gigabyte offset.
// - Upper kernel segment addresses pass through unchanged.
// - No program address lands in physical 512 MB up to 1 GB.
// - Low 512 MB holds eight 64 MB subsegments, each 8, 16 or 32 bits.
// - A low subsegment width serves cached and uncached windows alike.
// - User segment has four 512 MB subsegments with own widths.
// - Upper kernel segment has two 512 MB subsegments with own widths.
// - Wide access to a narrow subsegment splits into several bus phases.
// - Software issues every access as 32 bits; splitting is automatic.
// - Cached kernel window clears the top bit and always uses the cache.
// - Uncached kernel window clears three top bits and never uses the cache.
package pam_pkg;

    // =================================================================
    // Register map.
    localparam logic [3:0]  REG_MODE     = 4'h0;
    localparam logic [3:0]  REG_WID_LOW  = 4'h1;
    localparam logic [3:0]  REG_WID_USR  = 4'h2;
    localparam logic [3:0]  REG_WID_UPK  = 4'h3;
    localparam logic [3:0]  REG_STATUS   = 4'h4;
    localparam logic [3:0]  REG_MASK     = 4'h5;
    localparam logic [3:0]  REG_FAULT    = 4'h6;

    // Width codes, two bits each.
    localparam logic [1:0]  WID_32       = 2'h0;
    localparam logic [1:0]  WID_16       = 2'h1;
    localparam logic [1:0]  WID_8        = 2'h2;

    // Reset values.
    localparam logic        MODE_RESET   = 1'h0;
    localparam logic [15:0] WID_LOW_RST  = 16'h0000;
    localparam logic [7:0]  WID_USR_RST  = 8'h00;
    localparam logic [3:0]  WID_UPK_RST  = 4'h0;

    // Translation constants.
    localparam logic [31:0] USER_OFFSET  = 32'h4000_0000;
    localparam logic [31:0] LOW_MASK3    = 32'h1FFF_FFFF;

    // Status bit positions.
    localparam int          ST_ADDR_TRAP = 0;
    localparam int          ST_INSN_TRAP = 1;
    localparam int          ST_SPLIT     = 2;
    localparam int          ST_WIDTH     = 3;

    typedef enum {
        PAM_IDLE,
        PAM_PHASE
    } pam_state_t;

endpackage : pam_pkg

// ---- logic/pam_width_sel.sv ----
// Width lookup for one program address from the subsegment settings.
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Width selection
module pam_width_sel (
    input  wire logic [31:0] prog_addr,
    input  wire logic [15:0] wid_low,
    input  wire logic [7:0]  wid_usr,
    input  wire logic [3:0]  wid_upk,
    output logic      [1:0]  width
);

    // Selection uses untranslated upper bits, so mode cannot affect it.
    always_comb begin
        if (!prog_addr[31]) begin
            width = wid_usr[{prog_addr[30:29], 1'b0} +: 2];
        end else if (prog_addr[30]) begin
            width = wid_upk[{prog_addr[29], 1'b0} +: 2];
        end else begin
            // Both kernel windows index the same eight settings.
            width = wid_low[{prog_addr[28:26], 1'b0} +: 2];
        end
    end

endmodule // pam_width_sel
`default_nettype wire

// ---- logic/pam_mapper.sv ----
// Program address mapper with privilege check and narrow port splitting.
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Top of the mapper
module pam_mapper (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    // Core request side.
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [31:0] req_addr,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    input  wire logic        insn_priv,
    input  wire logic        mode_enter_user,
    input  wire logic        mode_enter_kernel,
    output logic             trap_addr,
    output logic             trap_insn,
    output logic             user_mode,
    // Bus side.
    output logic             bus_valid,
    input  wire logic        bus_ready,
    output logic      [31:0] bus_addr,
    output logic             bus_write,
    output logic      [31:0] bus_wdata,
    output logic      [1:0]  bus_width,
    output logic             bus_cached,
    output logic             bus_last
);

    typedef struct packed {
        logic              user;
        logic [15:0]       wid_low;
        logic [7:0]        wid_usr;
        logic [3:0]        wid_upk;
        logic [3:0]        status;
        logic [3:0]        mask;
        logic [31:0]       fault;
        logic [31:0]       rdata;
        logic              trap_a;
        logic              trap_i;
        pam_pkg::pam_state_t state;
        logic              bvalid;
        logic [31:0]       baddr;
        logic              bwrite;
        logic [31:0]       bwdata;
        logic [1:0]        bwidth;
        logic              bcached;
        logic [2:0]        left;
    } pam_state_s_t;

    pam_state_s_t state_ff;
    pam_state_s_t nxt_state;

    logic [1:0]  sel_width;
    logic [31:0] phys;
    logic        cached;
    logic        addr_bad;
    logic        accept;
    logic [2:0]  phases;
    logic [3:0]  w1c;

    pam_width_sel u_width (
        .prog_addr (req_addr),
        .wid_low   (state_ff.wid_low),
        .wid_usr   (state_ff.wid_usr),
        .wid_upk   (state_ff.wid_upk),
        .width     (sel_width)
    );

    // =================================================================
    // Translation. The mode is never consulted here.
    always_comb begin
        phys   = req_addr;
        cached = 1'b0;
        if (!req_addr[31]) begin
            phys = req_addr + pam_pkg::USER_OFFSET;
        end else if (req_addr[31:29] == 3'h4) begin
            phys   = {1'b0, req_addr[30:0]};
            cached = 1'b1;
        end else if (req_addr[31:29] == 3'h5) begin
            phys   = req_addr & pam_pkg::LOW_MASK3;
        end else begin
            phys   = req_addr;
        end
    end

    // Kernel passes all; user fails on the top bit.
    assign addr_bad = state_ff.user && req_addr[31];
    assign req_ready = (state_ff.state == pam_pkg::PAM_IDLE) && !state_ff.bvalid;
    assign accept    = req_valid && req_ready;

    // Phase count follows the port width; 32-bit is one phase.
    always_comb begin
        unique case (sel_width)
            pam_pkg::WID_16: begin
                phases = 3'h2;
            end
            pam_pkg::WID_8: begin
                phases = 3'h4;
            end
            default: begin
                phases = 3'h1;
            end
        endcase
    end

    assign w1c = (reg_wr && reg_addr == pam_pkg::REG_STATUS) ? reg_wdata[3:0] : 4'h0;

    // =================================================================
    // Next state.
    always_comb begin
        nxt_state        = state_ff;
        nxt_state.trap_a = 1'b0;
        nxt_state.trap_i = 1'b0;
        nxt_state.rdata  = 32'h0000_0000;
        nxt_state.status = state_ff.status & ~w1c;

        // Mode changes from the core's exception and return logic.
        if (mode_enter_kernel) begin
            nxt_state.user = 1'b0;
        end else if (mode_enter_user) begin
            nxt_state.user = 1'b1;
        end

        // Privileged instructions are refused in user mode.
        if (insn_priv && state_ff.user) begin
            nxt_state.trap_i                     = 1'b1;
            nxt_state.status[pam_pkg::ST_INSN_TRAP] = 1'b1;
        end

        // Register writes. Mode bit writes are kernel software's path.
        if (reg_wr) begin
            unique case (reg_addr)
                pam_pkg::REG_MODE:    nxt_state.user    = reg_wdata[0];
                pam_pkg::REG_WID_LOW: nxt_state.wid_low = reg_wdata[15:0];
                pam_pkg::REG_WID_USR: nxt_state.wid_usr = reg_wdata[7:0];
                pam_pkg::REG_WID_UPK: nxt_state.wid_upk = reg_wdata[3:0];
                pam_pkg::REG_MASK:    nxt_state.mask    = reg_wdata[3:0];
                default: ;
            endcase
        end

        // Register reads, data in the following cycle.
        if (reg_rd) begin
            unique case (reg_addr)
                pam_pkg::REG_MODE:    nxt_state.rdata = {31'h0, state_ff.user};
                pam_pkg::REG_WID_LOW: nxt_state.rdata = {16'h0, state_ff.wid_low};
                pam_pkg::REG_WID_USR: nxt_state.rdata = {24'h0, state_ff.wid_usr};
                pam_pkg::REG_WID_UPK: nxt_state.rdata = {28'h0, state_ff.wid_upk};
                pam_pkg::REG_STATUS:  nxt_state.rdata = {28'h0, state_ff.status};
                pam_pkg::REG_MASK:    nxt_state.rdata = {28'h0, state_ff.mask};
                pam_pkg::REG_FAULT:   nxt_state.rdata = state_ff.fault;
                default:              nxt_state.rdata = 32'h0000_0000;
            endcase
        end

        // Bus phase sequencing.
        unique case (state_ff.state)
            pam_pkg::PAM_IDLE: begin
                if (state_ff.bvalid && bus_ready) begin
                    nxt_state.bvalid = 1'b0;
                end
                if (accept) begin
                    if (addr_bad) begin
                        nxt_state.trap_a = 1'b1;
                        nxt_state.fault  = req_addr;
                        nxt_state.status[pam_pkg::ST_ADDR_TRAP] = 1'b1;
                    end else begin
                        nxt_state.bvalid  = 1'b1;
                        nxt_state.baddr   = phys;
                        nxt_state.bwrite  = req_write;
                        nxt_state.bwdata  = req_wdata;
                        nxt_state.bwidth  = sel_width;
                        nxt_state.bcached = cached;
                        nxt_state.left    = phases - 3'h1;
                        if (phases != 3'h1) begin
                            nxt_state.state = pam_pkg::PAM_PHASE;
                            nxt_state.status[pam_pkg::ST_SPLIT] = 1'b1;
                        end
                    end
                end
            end
            pam_pkg::PAM_PHASE: begin
                if (bus_ready) begin
                    if (state_ff.left == 3'h0) begin
                        nxt_state.bvalid = 1'b0;
                        nxt_state.state  = pam_pkg::PAM_IDLE;
                    end else begin
                        nxt_state.left = state_ff.left - 3'h1;
                        if (state_ff.bwidth == pam_pkg::WID_16) begin
                            nxt_state.baddr  = state_ff.baddr + 32'h0000_0002;
                            nxt_state.bwdata = {16'h0, state_ff.bwdata[31:16]};
                        end else begin
                            nxt_state.baddr  = state_ff.baddr + 32'h0000_0001;
                            nxt_state.bwdata = {8'h0, state_ff.bwdata[31:8]};
                        end
                    end
                end
            end
        endcase

        // Illegal width code seen on a request is flagged.
        if (accept && sel_width == 2'h3) begin
            nxt_state.status[pam_pkg::ST_WIDTH] = 1'b1;
        end
    end

    // =================================================================
    // State register. Reset lands in kernel mode.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff         <= '0;
            state_ff.user    <= pam_pkg::MODE_RESET;
            state_ff.wid_low <= pam_pkg::WID_LOW_RST;
            state_ff.wid_usr <= pam_pkg::WID_USR_RST;
            state_ff.wid_upk <= pam_pkg::WID_UPK_RST;
            state_ff.state   <= pam_pkg::PAM_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // =================================================================
    // Outputs.
    assign reg_rdata  = state_ff.rdata;
    assign irq        = |(state_ff.status & state_ff.mask);
    assign trap_addr  = state_ff.trap_a;
    assign trap_insn  = state_ff.trap_i;
    assign user_mode  = state_ff.user;
    assign bus_valid  = state_ff.bvalid;
    assign bus_addr   = state_ff.baddr;
    assign bus_write  = state_ff.bwrite;
    assign bus_wdata  = state_ff.bwdata;
    assign bus_width  = state_ff.bwidth;
    assign bus_cached = state_ff.bcached;
    assign bus_last   = state_ff.bvalid && state_ff.left == 3'h0;

endmodule // pam_mapper
`default_nettype wire

// ---- testbench/pam_bus_model.sv ----
// Bus partner that answers the mapper's data phases promptly or slowly.
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Bus partner
module pam_bus_model (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    input  wire logic bus_valid,
    input  wire logic slow,
    output logic      bus_ready
);
    logic toggle_ff;

    // Slow mode accepts every other cycle, so the mapper must hold a phase.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            toggle_ff <= 1'h0;
        else
            toggle_ff <= ~toggle_ff;
    end

    // Ready only answers a phase that is offered.
    assign bus_ready = bus_valid && (!slow || toggle_ff);
endmodule // pam_bus_model
`default_nettype wire

// ---- testbench/pam_checker.sv ----
// Concurrent checks on the ports of the program address mapper.
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Checker
module pam_checker (
    input wire logic        ref_clk,
    input wire logic        reset_n,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [31:0] req_addr,
    input wire logic        insn_priv,
    input wire logic        trap_addr,
    input wire logic        trap_insn,
    input wire logic        user_mode,
    input wire logic        bus_valid,
    input wire logic        bus_ready,
    input wire logic [31:0] bus_addr,
    input wire logic [1:0]  bus_width,
    input wire logic        bus_cached,
    input wire logic        bus_last
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // A request is taken, and a phase steps on to the next one.
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_step; bus_valid && bus_ready && !bus_last; endsequence

    property p_reset_kernel; $rose(reset_n) |-> !user_mode; endproperty
    property p_kernel_free; s_take ##0 !user_mode |=> !trap_addr; endproperty
    property p_user_trap;
        s_take ##0 (user_mode && req_addr[31]) |=> trap_addr && !bus_valid;
    endproperty
    property p_insn; insn_priv |=> trap_insn == $past(user_mode); endproperty
    property p_user_map;
        s_take ##0 !req_addr[31] |=> bus_valid && bus_addr == $past(req_addr) + 32'h4000_0000;
    endproperty
    property p_upper;
        s_take ##0 (!user_mode && req_addr[31:30] == 2'h3) |=> bus_addr == $past(req_addr);
    endproperty
    property p_cached;
        s_take ##0 (!user_mode && req_addr[31:29] == 3'h4)
            |=> bus_cached && bus_addr == {1'h0, $past(req_addr[30:0])};
    endproperty
    property p_uncached;
        s_take ##0 (!user_mode && req_addr[31:29] == 3'h5)
            |=> !bus_cached && bus_addr == {3'h0, $past(req_addr[28:0])};
    endproperty
    property p_no_gap; bus_valid |-> bus_addr[31:29] != 3'h1; endproperty
    property p_phase_step;
        s_step |=> bus_valid && bus_addr == $past(bus_addr)
            + (($past(bus_width) == pam_pkg::WID_16) ? 32'h2 : 32'h1);
    endproperty
    property p_wide_single;
        bus_valid && bus_width == pam_pkg::WID_32 |-> bus_last;
    endproperty

    a_reset_kernel: assert property (p_reset_kernel)
        else $error("mode is not kernel after reset");
    a_kernel_free: assert property (p_kernel_free)
        else $error("kernel access trapped");
    a_user_trap: assert property (p_user_trap)
        else $error("user access to upper half not trapped");
    a_insn: assert property (p_insn)
        else $error("privileged instruction trap wrong");
    a_user_map: assert property (p_user_map)
        else $error("user segment offset wrong");
    a_upper: assert property (p_upper)
        else $error("upper kernel address changed");
    a_cached: assert property (p_cached)
        else $error("cached window mapping wrong");
    a_uncached: assert property (p_uncached)
        else $error("uncached window mapping wrong");
    a_no_gap: assert property (p_no_gap)
        else $error("physical address in the gap");
    a_phase_step: assert property (p_phase_step)
        else $error("phase address step wrong");
    a_wide_single: assert property (p_wide_single)
        else $error("wide port split");
endmodule // pam_checker

bind pam_mapper pam_checker u_pam_checker (.ref_clk, .reset_n, .req_valid, .req_ready,
    .req_addr, .insn_priv, .trap_addr, .trap_insn, .user_mode, .bus_valid, .bus_ready,
    .bus_addr, .bus_width, .bus_cached, .bus_last);
`default_nettype wire

// ---- testbench/pam_mapper_bench.sv ----
// Self-checking bench for the program address mapper.
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// Bench top
module pam_mapper_bench;
    logic        ref_clk, reset_n, reg_wr, reg_rd, irq, req_valid, req_ready, req_write;
    logic        insn_priv, mode_enter_user, mode_enter_kernel, trap_addr, trap_insn;
    logic        user_mode, bus_valid, bus_ready, bus_write, bus_cached, bus_last, slow;
    logic        trapped, pc, pwr;
    logic [3:0]  reg_addr;
    logic [1:0]  bus_width, pw;
    logic [31:0] reg_wdata, reg_rdata, req_addr, req_wdata, bus_addr, bus_wdata, rd;
    logic [31:0] pa [4];
    logic [31:0] pd [4];
    int          failures = 0, compares = 0, n, cycles = 0;

    pam_mapper u_pam_mapper (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq, .req_valid, .req_ready, .req_addr, .req_write, .req_wdata,
        .insn_priv, .mode_enter_user, .mode_enter_kernel, .trap_addr, .trap_insn,
        .user_mode, .bus_valid, .bus_ready, .bus_addr, .bus_write, .bus_wdata, .bus_width,
        .bus_cached, .bus_last);
    pam_bus_model u_pam_bus_model (.ref_clk, .reset_n, .bus_valid, .slow, .bus_ready);

    // Clock at 40 MHz.
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // The whole run needs well under 3000 cycles, so 6000 means a hang.
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            failures++;
            stop_test();
        end
    end

    // =================================================================
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Writes land at the second edge; status effects are seen just after.
    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
        @(negedge ref_clk);
    endtask

    task automatic reg_read(input logic [3:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'h1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        rd = reg_rdata;
    endtask

    // Issues one request from idle and records every accepted phase.
    task automatic access(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        // The low data bit picks the direction, so both directions are exercised.
        req_valid <= 1'h1; req_addr <= a; req_wdata <= d; req_write <= d[0];
        @(posedge ref_clk);
        req_valid <= 1'h0;
        n = 0;
        trapped = 1'h0;
        repeat (20) begin
            @(negedge ref_clk);
            trapped |= trap_addr;
            if (bus_valid && bus_ready && n < 4) begin
                pa[n] = bus_addr; pd[n] = bus_wdata; pw = bus_width; pc = bus_cached;
                pwr = bus_write;
                n++;
                if (bus_last) break;
            end
        end
    endtask

    task automatic pulse_insn(input logic exp);
        @(posedge ref_clk);
        insn_priv <= 1'h1;
        @(posedge ref_clk);
        insn_priv <= 1'h0;
        @(negedge ref_clk);
        check(trap_insn, exp);
    endtask

    // =================================================================
    // Scenarios
    task automatic t_reset();
        check(user_mode, 0);
        for (int i = 0; i < 8; i++) begin
            reg_read(i == 7 ? 4'hF : 4'(i));
            check(rd, 0);
        end
    endtask

    task automatic t_translate();
        logic [31:0] ta [5] = '{32'h1234_5678, 32'h7FFF_FFFC, 32'h8123_4567, 32'hBFC0_0000,
                                32'hC000_0010};
        logic [31:0] tp [5] = '{32'h5234_5678, 32'hBFFF_FFFC, 32'h0123_4567, 32'h1FC0_0000,
                                32'hC000_0010};
        for (int i = 0; i < 5; i++) begin
            access(ta[i], 32'h1357_9BDE + i);
            check(n, 1);
            check(pa[0], tp[i]);
            check(pd[0], 32'h1357_9BDE + i);
            check(pwr, i % 2);
            if (i == 2 || i == 3) check(pc, i == 2);
        end
    endtask

    task automatic t_user();
        @(posedge ref_clk);
        mode_enter_user <= 1'h1;
        @(posedge ref_clk);
        mode_enter_user <= 1'h0;
        access(32'h1000_0000, 0);
        check(pa[0], 32'h5000_0000);
        access(32'h8000_0000, 0);
        check(trapped, 1);
        check(n, 0);
        access(32'hC000_0000, 0);
        check(trapped, 1);
        pulse_insn(1'h1);
        reg_read(pam_pkg::REG_STATUS);
        check(rd, 32'h3);
        reg_read(pam_pkg::REG_FAULT);
        check(rd, 32'hC000_0000);
        check(irq, 0);
        reg_write(pam_pkg::REG_MASK, 32'h2);
        check(irq, 1);
        reg_write(pam_pkg::REG_STATUS, 32'h2);
        check(irq, 0);
        reg_write(pam_pkg::REG_STATUS, 32'h1);
        reg_read(pam_pkg::REG_STATUS);
        check(rd, 0);
        @(posedge ref_clk);
        mode_enter_kernel <= 1'h1;
        @(posedge ref_clk);
        mode_enter_kernel <= 1'h0;
        pulse_insn(1'h0);
        access(32'h8000_0000, 0);
        check({trapped, 4'(n)}, 32'h1);
    endtask

    // Widths: low sub 1 at 16 and 7 at 8, user sub 2 at 8, upper sub 1 at 16.
    task automatic t_width();
        logic [31:0] wa [7] = '{32'h8400_0000, 32'hA400_0000, 32'h9C00_0010, 32'h4000_0000,
                                32'h2000_0000, 32'hE000_0000, 32'hC000_0000};
        logic [31:0] wp [7] = '{32'h0400_0000, 32'h0400_0000, 32'h1C00_0010, 32'h8000_0000,
                                32'h6000_0000, 32'hE000_0000, 32'hC000_0000};
        int          ws [7] = '{2, 2, 1, 1, 4, 2, 4};
        logic [31:0] lane;
        slow <= 1'h1;
        reg_write(pam_pkg::REG_WID_LOW, 32'h8004);
        reg_write(pam_pkg::REG_WID_USR, 32'h20);
        reg_write(pam_pkg::REG_WID_UPK, 32'h4);
        reg_read(pam_pkg::REG_WID_LOW);
        check(rd, 32'h8004);
        for (int i = 0; i < 7; i++) begin
            access(wa[i], 32'hAABB_CCDD);
            check(n, 4 / ws[i]);
            check(pw, ws[i] == 4 ? 0 : 3 - ws[i]);
            for (int k = 0; k < n; k++) begin
                check(pa[k], wp[i] + k * ws[i]);
                // Only the lanes of the port width are compared in a phase.
                lane = 32'((64'h1 << (8 * ws[i])) - 1);
                check(pd[k] & lane, (32'hAABB_CCDD >> (8 * ws[i] * k)) & lane);
            end
        end
        reg_read(pam_pkg::REG_STATUS);
        check(rd, 32'h4);
        // Width code 3 is not a legal port width; it runs as one phase and is flagged.
        reg_write(pam_pkg::REG_WID_UPK, 32'h3);
        access(32'hC000_0000, 32'h0);
        check(n, 1);
        check(pw, 3);
        reg_read(pam_pkg::REG_STATUS);
        check(rd, 32'hC);
    endtask

    // =================================================================
    // Main sequence
    initial begin
        reset_n = 1'h0; reg_wr = 1'h0; reg_rd = 1'h0; reg_addr = 4'h0; reg_wdata = 32'h0;
        req_valid = 1'h0; req_addr = 32'h0; req_write = 1'h0; req_wdata = 32'h0; slow = 1'h0;
        insn_priv = 1'h0; mode_enter_user = 1'h0; mode_enter_kernel = 1'h0;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        t_reset();
        t_translate();
        t_user();
        t_width();
        stop_test();
    end
endmodule // pam_mapper_bench
`default_nettype wire
